/* rtl/lmc_ctrl.sv */
// top of the line motion, cut and press output sequencer
// ----------------------------------------------------------------
// Summary of operation
// R1: fast/slow run drive forward, speed and run
// R2: jog drives slow plus direction, no run
// R3: halted/idle: motion off, slow follows hold setting
// R4: run granted only with job, no error
// R5: motion stop keeps run output on
// R6: keep cutting on targets while coasting
// R7: stop-after-cut drops forward after each cut
// R8: run or interlock opening leaves run mode
// R9: position tracking continues during emergency stop
// R10: cut selectable flying or feed-to-stop, up/assist
// R11: cut down dwell programmable 0.000 to 9.999 s
// R12: cut complete ends down dwell at once
// R13: cut up dwell always runs full time
// R14: press down plus up or assist output
// R15: press down dwell programmable 0.000 to 9.999 s
// R16: press complete ends down dwell at once
// R17: jog inputs ignored in run mode
// R18: halted jog held drives slow and direction
// R19: refused run posts a warning
// R20: dwells count 1 ms steps, inputs synchronised
// ----------------------------------------------------------------
`timescale 1ns/1ps
module lmc_ctrl
  import lmc_pkg::*;
(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // operator and machine contacts
  input  wire logic        RUN_IN,
  input  wire logic        INTERLOCK_IN,
  input  wire logic        JOG_FWD_IN,
  input  wire logic        JOG_REV_IN,
  input  wire logic        CUT_COMPLETE_IN,
  input  wire logic        PRESS_COMPLETE_IN,
  // job status from the sequencer
  input  wire logic        JOB_READY,
  input  wire logic        ERROR_ACTIVE,
  input  wire logic        SPEED_FAST,
  input  wire logic        MOTION_REQ,
  input  wire logic        CUT_TARGET,
  input  wire logic        PRESS_TARGET,
  // configuration
  input  wire logic        SLOW_HOLD,
  input  wire logic        FEED_TO_STOP,
  input  wire logic        STOP_AFTER_CUT,
  input  wire logic        CUT_ASSIST_SEL,
  input  wire logic        PRESS_ASSIST_SEL,
  input  wire logic [13:0] CUT_DOWN_MS,
  input  wire logic [13:0] CUT_UP_MS,
  input  wire logic [13:0] PRESS_DOWN_MS,
  input  wire logic [13:0] PRESS_UP_MS,
  // motion outputs
  output logic             FORWARD,
  output logic             FAST,
  output logic             SLOW,
  output logic             REVERSE,
  output logic             RUN,
  // cut and press outputs
  output logic             CUT_DOWN,
  output logic             CUT_UP,
  output logic             CUT_DIE_ASSIST_OUTPUT,
  output logic             STAMP_DOWN,
  output logic             STAMP_UP,
  output logic             STAMP_DIE_ASSIST_OUTPUT,
  // status
  output logic             RUN_WARNING,
  output logic             COASTING,
  output logic             TRACK_ENABLE
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int N_IN = 6;

  logic [N_IN-1:0] raw_in;
  logic [N_IN-1:0] sync_a;
  logic [N_IN-1:0] sync_b;

  assign raw_in = {PRESS_COMPLETE_IN, CUT_COMPLETE_IN, JOG_REV_IN,
                   JOG_FWD_IN, INTERLOCK_IN, RUN_IN};

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_sync
      // first stage feeds only the second stage
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= raw_in[gi];  // [R20]
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic run_s;
  logic ilk_s;
  logic jfwd_s;
  logic jrev_s;
  logic cut_done_s;
  logic press_done_s;

  assign run_s        = sync_b[0];
  assign ilk_s        = sync_b[1];
  assign jfwd_s       = sync_b[2];
  assign jrev_s       = sync_b[3];
  assign cut_done_s   = sync_b[4];
  assign press_done_s = sync_b[5];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    lmc_line_t   line;
    logic [16:0] step_cnt;
    logic        step;
    logic        run_prev;
    logic        warn;
    logic        coast;
    logic        cut_hold;
    logic        cut_busy_q;
    lmc_motion_t mo;
    logic        track;
  } lmc_state_t;

  lmc_state_t s;
  lmc_state_t next_s;

  lmc_dwell_cfg_t cut_cfg;
  lmc_dwell_cfg_t press_cfg;
  lmc_dwell_out_t cut_o;
  lmc_dwell_out_t press_o;
  logic           cut_fire;
  logic           press_fire;
  logic           run_ok;
  logic           in_run;

  assign cut_cfg   = '{down_ms: CUT_DOWN_MS, up_ms: CUT_UP_MS, assist_sel: CUT_ASSIST_SEL};
  assign press_cfg = '{down_ms: PRESS_DOWN_MS, up_ms: PRESS_UP_MS,
                       assist_sel: PRESS_ASSIST_SEL};

  assign run_ok = run_s && ilk_s && JOB_READY && !ERROR_ACTIVE;  // [R4]
  assign in_run = (s.line == LMC_IDLE) || (s.line == LMC_FAST) || (s.line == LMC_SLOW);

  // targets fire in run and while coasting after a halt
  assign cut_fire   = CUT_TARGET && (in_run || s.coast) && !cut_o.busy;  // [R6]
  assign press_fire = PRESS_TARGET && (in_run || s.coast) && !press_o.busy;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (s.step_cnt == 17'(STEP_CYCLES - 1)) begin
      next_s.step_cnt = STEP_CNT_RST;
      next_s.step     = 1'b1;  // [R20]
    end else begin
      next_s.step_cnt = s.step_cnt + 17'h00001;
      next_s.step     = 1'b0;
    end

    next_s.run_prev = run_s;
    // warning stays posted until the run contact is released
    if (run_s && !s.run_prev && !run_ok && !in_run) begin
      next_s.warn = 1'b1;  // [R19]
    end else if (!run_s) begin
      next_s.warn = 1'b0;
    end

    case (s.line)
      LMC_HALT, LMC_JOG_FWD, LMC_JOG_REV: begin
        // a fresh run request is needed, a held contact does not retry
        if (run_s && !s.run_prev && run_ok) begin
          next_s.line = LMC_IDLE;  // [R4]
        end else if (jfwd_s && !jrev_s) begin
          next_s.line = LMC_JOG_FWD;  // [R18]
        end else if (jrev_s && !jfwd_s) begin
          next_s.line = LMC_JOG_REV;  // [R18]
        end else begin
          next_s.line = LMC_HALT;
        end
      end
      LMC_IDLE, LMC_FAST, LMC_SLOW: begin
        // jog inputs are not looked at here
        if (!run_s || !ilk_s || ERROR_ACTIVE) begin  // [R8] [R17]
          next_s.line  = LMC_HALT;
          next_s.coast = 1'b1;
        end else if (MOTION_REQ && !s.cut_hold) begin
          next_s.line = SPEED_FAST ? LMC_FAST : LMC_SLOW;
        end else begin
          next_s.line = LMC_IDLE;  // [R5]
        end
      end
      default: next_s.line = LMC_HALT;
    endcase

    // coasting ends once no target is pending and both dwells are done
    if (s.coast && !CUT_TARGET && !PRESS_TARGET && !cut_o.busy && !press_o.busy) begin
      next_s.coast = 1'b0;
    end
    if (next_s.line == LMC_IDLE && s.line != LMC_IDLE && !in_run) begin
      next_s.coast = 1'b0;
    end

    // hold motion off from a cut until its dwell completes
    next_s.cut_busy_q = cut_o.busy;
    if ((STOP_AFTER_CUT || FEED_TO_STOP) && cut_fire) begin
      next_s.cut_hold = 1'b1;  // [R7] [R10]
    end else if (s.cut_busy_q && !cut_o.busy) begin
      next_s.cut_hold = 1'b0;
    end else if (!in_run) begin
      next_s.cut_hold = 1'b0;
    end

    case (next_s.line)
      LMC_FAST:    next_s.mo = '{fwd: 1'b1, fast: 1'b1, slow: 1'b0, rev: 1'b0, run: 1'b1};  // [R1]
      LMC_SLOW:    next_s.mo = '{fwd: 1'b1, fast: 1'b0, slow: 1'b1, rev: 1'b0, run: 1'b1};  // [R1]
      LMC_JOG_FWD: next_s.mo = '{fwd: 1'b1, fast: 1'b0, slow: 1'b1, rev: 1'b0, run: 1'b0};  // [R2]
      LMC_JOG_REV: next_s.mo = '{fwd: 1'b0, fast: 1'b0, slow: 1'b1, rev: 1'b1, run: 1'b0};  // [R2]
      LMC_IDLE:    next_s.mo = '{fwd: 1'b0, fast: 1'b0, slow: SLOW_HOLD, rev: 1'b0, run: 1'b1};  // [R3] [R5]
      default:     next_s.mo = '{fwd: 1'b0, fast: 1'b0, slow: SLOW_HOLD, rev: 1'b0, run: 1'b0};  // [R3]
    endcase

    // tracking never stops for an emergency stop; only reset clears it
    next_s.track = 1'b1;  // [R9]
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s <= '{line: LMC_HALT, step_cnt: STEP_CNT_RST, mo: '0, default: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // dwell channels
  // ----------------------------------------------------------------
  lmc_dwell u_cut (
    .REF_CLK  (REF_CLK),
    .RST      (RST),
    .step     (s.step),
    .fire     (cut_fire),
    .complete (cut_done_s),  // [R12]
    .cfg      (cut_cfg),
    .dout     (cut_o)
  );

  lmc_dwell u_press (
    .REF_CLK  (REF_CLK),
    .RST      (RST),
    .step     (s.step),
    .fire     (press_fire),
    .complete (press_done_s),  // [R16]
    .cfg      (press_cfg),
    .dout     (press_o)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign FORWARD                 = s.mo.fwd;
  assign FAST                    = s.mo.fast;
  assign SLOW                    = s.mo.slow;
  assign REVERSE                 = s.mo.rev;
  assign RUN                     = s.mo.run;
  assign CUT_DOWN                = cut_o.down;
  assign CUT_UP                  = cut_o.up;
  assign CUT_DIE_ASSIST_OUTPUT   = cut_o.assist;
  assign STAMP_DOWN              = press_o.down;
  assign STAMP_UP                = press_o.up;
  assign STAMP_DIE_ASSIST_OUTPUT = press_o.assist;
  assign RUN_WARNING             = s.warn;
  assign COASTING                = s.coast;
  assign TRACK_ENABLE            = s.track;

endmodule : lmc_ctrl

/* rtl/lmc_dwell.sv */
// one timed down/up dwell channel with a complete-switch override
`timescale 1ns/1ps
module lmc_dwell
  import lmc_pkg::*;
(
  // clock and reset
  input  wire logic           REF_CLK,
  input  wire logic           RST,
  // timing
  input  wire logic           step,
  // control
  input  wire logic           fire,
  input  wire logic           complete,
  input  wire lmc_dwell_cfg_t cfg,
  // outputs
  output lmc_dwell_out_t      dout
);

  typedef struct packed {
    lmc_dwell_st_t  st;
    logic [13:0]    ms;
    lmc_dwell_out_t o;
  } lmc_dw_state_t;

  lmc_dw_state_t s;
  lmc_dw_state_t next_s;

  function automatic logic [13:0] lmc_clip(input logic [13:0] v);
    lmc_clip = (v > DWELL_MAX_MS) ? DWELL_MAX_MS : v;
  endfunction : lmc_clip

  always_comb begin
    next_s = s;
    case (s.st)
      LMC_DW_OFF: begin
        if (fire && lmc_clip(cfg.down_ms) != DWELL_RST) begin
          next_s.st = LMC_DW_DOWN;  // [R11] [R15]
          next_s.ms = lmc_clip(cfg.down_ms);
        end
      end
      LMC_DW_DOWN: begin
        // complete contact ends the down stroke at once
        if (complete || s.ms == DWELL_RST || (step && s.ms == 14'h0001)) begin  // [R12] [R16]
          next_s.st = cfg.assist_sel ? LMC_DW_BST : LMC_DW_UP;  // [R10] [R14]
          next_s.ms = lmc_clip(cfg.up_ms);
        end else if (step) begin
          next_s.ms = s.ms - 14'h0001;  // [R20]
        end
      end
      LMC_DW_UP, LMC_DW_BST: begin
        // up/assist ignores the complete input and runs its full time
        if (s.ms == DWELL_RST || (step && s.ms == 14'h0001)) begin  // [R13]
          next_s.st = LMC_DW_OFF;
          next_s.ms = DWELL_RST;
        end else if (step) begin
          next_s.ms = s.ms - 14'h0001;
        end
      end
      default: begin
        next_s.st = LMC_DW_OFF;
        next_s.ms = DWELL_RST;
      end
    endcase
    next_s.o.down   = (next_s.st == LMC_DW_DOWN);
    next_s.o.up     = (next_s.st == LMC_DW_UP);
    next_s.o.assist = (next_s.st == LMC_DW_BST);
    next_s.o.busy   = (next_s.st != LMC_DW_OFF);
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s <= '{st: LMC_DW_OFF, ms: DWELL_RST, o: '0};
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.o;

endmodule : lmc_dwell

/* rtl/lmc_pkg.sv */
// package of constants and carrier types for the line motion and cut control
package lmc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 125000000;
  localparam int STEP_TIME_US   = 1000;
  localparam int STEP_CYCLES    = (CLK_HZ / 1000000) * STEP_TIME_US;
  localparam int STEP_CNT_W     = 17;
  localparam logic [13:0] DWELL_MAX_MS = 14'h270F;
  localparam int DWELL_W        = 14;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [16:0] STEP_CNT_RST = 17'h00000;
  localparam logic [13:0] DWELL_RST    = 14'h0000;

  // ----------------------------------------------------------------
  // line and dwell states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LMC_HALT    = 3'b000,
    LMC_JOG_FWD = 3'b001,
    LMC_JOG_REV = 3'b010,
    LMC_IDLE    = 3'b011,
    LMC_FAST    = 3'b100,
    LMC_SLOW    = 3'b101
  } lmc_line_t;

  typedef enum logic [1:0] {
    LMC_DW_OFF  = 2'b00,
    LMC_DW_DOWN = 2'b01,
    LMC_DW_UP   = 2'b10,
    LMC_DW_BST  = 2'b11
  } lmc_dwell_st_t;

  // motion outputs travel together
  typedef struct packed {
    logic fwd;
    logic fast;
    logic slow;
    logic rev;
    logic run;
  } lmc_motion_t;

  // dwell channel setup
  typedef struct packed {
    logic [13:0] down_ms;
    logic [13:0] up_ms;
    logic        assist_sel;
  } lmc_dwell_cfg_t;

  // dwell channel outputs
  typedef struct packed {
    logic down;
    logic up;
    logic assist;
    logic busy;
  } lmc_dwell_out_t;

endpackage : lmc_pkg

/* tb/lmc_ctrl_assertions.sv */
// port-level checks for the line motion and cut control
`timescale 1ns/1ps
module lmc_ctrl_chk
  import lmc_pkg::*;
(
  // clock, reset and inputs
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic INTERLOCK_IN,
  input wire logic CUT_COMPLETE_IN,
  input wire logic PRESS_COMPLETE_IN,
  input wire logic JOB_READY,
  input wire logic ERROR_ACTIVE,
  input wire logic SLOW_HOLD,
  input wire logic STOP_AFTER_CUT,
  // outputs
  input wire logic FORWARD,
  input wire logic FAST,
  input wire logic SLOW,
  input wire logic REVERSE,
  input wire logic RUN,
  input wire logic CUT_DOWN,
  input wire logic STAMP_DOWN,
  input wire logic RUN_WARNING,
  input wire logic TRACK_ENABLE
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  fast_run_drive_a: assert property (RUN && FAST |-> FORWARD && !SLOW && !REVERSE)
    else $error("fast run drive wrong");
  slow_run_drive_a: assert property (RUN && FORWARD && !FAST |-> SLOW && !REVERSE)
    else $error("slow run drive wrong");
  jog_fwd_drive_a: assert property (!RUN && FORWARD |-> SLOW && !FAST && !REVERSE)
    else $error("jog forward drive wrong");
  jog_rev_drive_a: assert property (REVERSE |-> SLOW && !FORWARD && !FAST && !RUN)
    else $error("jog reverse drive wrong");
  halt_slow_hold_a: assert property (!$past(RST) && !FORWARD && !REVERSE |-> SLOW == $past(SLOW_HOLD))
    else $error("slow hold not followed");
  run_grant_a: assert property ($rose(RUN) |-> $past(JOB_READY) && !$past(ERROR_ACTIVE))
    else $error("run granted without job");
  run_refuse_a: assert property ($rose(RUN_WARNING) |-> !RUN)
    else $error("warning while running");
  interlock_exit_a: assert property ($fell(INTERLOCK_IN) |-> ##[1:3] !RUN)
    else $error("run kept after interlock open");
  track_kept_a: assert property (!$past(RST) |-> TRACK_ENABLE)
    else $error("tracking dropped");
  cut_override_a: assert property (CUT_DOWN && CUT_COMPLETE_IN |-> ##[1:3] !CUT_DOWN)
    else $error("cut down kept after complete");
  press_override_a: assert property (STAMP_DOWN && PRESS_COMPLETE_IN |-> ##[1:3] !STAMP_DOWN)
    else $error("press down kept after complete");
  stop_cut_fwd_a: assert property (STOP_AFTER_CUT && CUT_DOWN && $past(CUT_DOWN, 2) |-> !FORWARD)
    else $error("forward kept during cut");
endmodule : lmc_ctrl_chk

bind lmc_ctrl lmc_ctrl_chk chk (.*);

/* tb/lmc_machine.sv */
// machine side: run latch relay, e-stop chain and complete switches
`timescale 1ns/1ps
module lmc_machine (
  // stimulus and design outputs
  input  wire logic clk,
  input  wire logic run_button,
  input  wire logic estop_ok,
  input  wire logic run_out,
  input  wire logic cut_down,
  input  wire logic press_down,
  // contacts
  output logic      run_in,
  output logic      interlock_in,
  output logic      cut_done,
  output logic      press_done
);
  // ----------------------------------------------------------------
  // relays and switches
  // ----------------------------------------------------------------
  logic [1:0] cut_sw = 2'h0;
  logic [1:0] press_sw = 2'h0;
  // latch contact around the momentary button, broken by the e-stop
  assign run_in = estop_ok & (run_button | run_out);
  assign interlock_in = estop_ok;
  // switch closes two cycles into the stroke, opens once the solenoid drops
  always_ff @(posedge clk) begin
    cut_sw <= {cut_sw[0], cut_down};
    press_sw <= {press_sw[0], press_down};
  end
  assign cut_done = cut_sw[1] & cut_down;
  assign press_done = press_sw[1] & press_down;
endmodule : lmc_machine

/* tb/testbench.sv */
// self-checking bench for the line motion and cut control
`timescale 1ns/1ps
module testbench
  import lmc_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic REF_CLK = 1'h0, RST = 1'h1;
  logic RUN_IN, INTERLOCK_IN, CUT_COMPLETE_IN, PRESS_COMPLETE_IN;
  logic JOG_FWD_IN = 1'h0, JOG_REV_IN = 1'h0, JOB_READY = 1'h0, ERROR_ACTIVE = 1'h0;
  logic SPEED_FAST = 1'h0, MOTION_REQ = 1'h0, CUT_TARGET = 1'h0, PRESS_TARGET = 1'h0;
  logic SLOW_HOLD = 1'h1, FEED_TO_STOP = 1'h0, STOP_AFTER_CUT = 1'h0;
  logic CUT_ASSIST_SEL = 1'h0, PRESS_ASSIST_SEL = 1'h0;
  // short down dwells: the complete switch ends them long before 1 ms
  logic [13:0] CUT_DOWN_MS = 14'h0001, CUT_UP_MS = 14'h0000;
  logic [13:0] PRESS_DOWN_MS = 14'h0001, PRESS_UP_MS = 14'h0000;
  logic FORWARD, FAST, SLOW, REVERSE, RUN, CUT_DOWN, CUT_UP, CUT_DIE_ASSIST_OUTPUT;
  logic STAMP_DOWN, STAMP_UP, STAMP_DIE_ASSIST_OUTPUT, RUN_WARNING, COASTING, TRACK_ENABLE;
  logic run_button = 1'h0, estop_ok = 1'h1;
  int fail_count = 0, checks_done = 0;

  lmc_ctrl uut (.*);
  lmc_machine mach (.clk(REF_CLK), .run_button(run_button), .estop_ok(estop_ok),
    .run_out(RUN), .cut_down(CUT_DOWN), .press_down(STAMP_DOWN), .run_in(RUN_IN),
    .interlock_in(INTERLOCK_IN), .cut_done(CUT_COMPLETE_IN), .press_done(PRESS_COMPLETE_IN));

  initial forever #4 REF_CLK = ~REF_CLK;

  task automatic cyc(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask : cyc

  task automatic chk_m(input lmc_motion_t exp);
    checks_done++;
    if ({FORWARD, FAST, SLOW, REVERSE, RUN} !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, {FORWARD, FAST, SLOW, REVERSE, RUN}, exp);
    end
  endtask : chk_m

  task automatic chk_b(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_b

  task automatic report_and_stop;
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    RST = 1'h0;
    cyc(2);
    chk_m(5'h04);
    chk_b(TRACK_ENABLE, 1'h1);
    JOG_FWD_IN = 1'h1;
    cyc(4);
    chk_m(5'h14);
    JOG_FWD_IN = 1'h0;
    JOG_REV_IN = 1'h1;
    cyc(4);
    chk_m(5'h06);
    JOG_REV_IN = 1'h0;
    for (int i = 0; i < 2; i++) begin
      JOB_READY = i[0];
      ERROR_ACTIVE = i[0];
      run_button = 1'h1;
      cyc(4);
      chk_b(RUN, 1'h0);
      chk_b(RUN_WARNING, 1'h1);
      run_button = 1'h0;
      cyc(4);
      chk_b(RUN_WARNING, 1'h0);
    end
    ERROR_ACTIVE = 1'h0;
    run_button = 1'h1;
    cyc(4);
    run_button = 1'h0;
    chk_m(5'h05);
    JOG_REV_IN = 1'h1;
    cyc(4);
    chk_m(5'h05);
    JOG_REV_IN = 1'h0;
    MOTION_REQ = 1'h1;
    SPEED_FAST = 1'h1;
    cyc(2);
    chk_m(5'h19);
    SPEED_FAST = 1'h0;
    cyc(2);
    chk_m(5'h15);
    // both channels, both up/assist selections, flying cut
    for (int k = 0; k < 4; k++) begin
      CUT_ASSIST_SEL = k[0];
      PRESS_ASSIST_SEL = k[0];
      CUT_TARGET = !k[1];
      PRESS_TARGET = k[1];
      cyc(1);
      CUT_TARGET = 1'h0;
      PRESS_TARGET = 1'h0;
      cyc(1);
      chk_b(k[1] ? STAMP_DOWN : CUT_DOWN, 1'h1);
      chk_m(5'h15);
      cyc(8);
      chk_b(|{CUT_DOWN, CUT_UP, CUT_DIE_ASSIST_OUTPUT, STAMP_DOWN, STAMP_UP, STAMP_DIE_ASSIST_OUTPUT}, 1'h0);
    end
    // stop-after-cut first, then feed-to-stop: both hold forward off through the dwell
    for (int j = 0; j < 2; j++) begin
      STOP_AFTER_CUT = !j[0];
      FEED_TO_STOP = j[0];
      CUT_TARGET = 1'h1;
      cyc(1);
      CUT_TARGET = 1'h0;
      cyc(3);
      chk_m(5'h05);
      cyc(8);
      chk_m(5'h15);
    end
    STOP_AFTER_CUT = 1'h0;
    FEED_TO_STOP = 1'h0;
    estop_ok = 1'h0;
    cyc(3);
    chk_b(RUN, 1'h0);
    chk_b(COASTING, 1'h1);
    chk_b(TRACK_ENABLE, 1'h1);
    CUT_TARGET = 1'h1;
    cyc(2);
    chk_b(CUT_DOWN, 1'h1);
    CUT_TARGET = 1'h0;
    cyc(10);
    chk_m(5'h04);
    chk_b(COASTING, 1'h0);
    SLOW_HOLD = 1'h0;
    cyc(2);
    chk_m(5'h00);
    report_and_stop();
  end

  // watchdog well beyond the 130 or so cycles the tests take
  initial begin
    #20000;
    fail_count++;
    report_and_stop();
  end
endmodule : testbench
